/* File: bench/srm_host_monitor.sv */
// pin timing checks for the sram host controller
`timescale 1ns/1ns
module srm_host_mon import srm_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // user side
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic req_ready,
   input wire logic rd_valid,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic retain_req,
   // memory pins
   input wire logic select_low_n,
   input wire logic select_high,
   input wire logic out_enable_n,
   input wire logic write_strobe_n,
   input wire logic [ADDR_W-1:0] word_address,
   input wire logic [DATA_W-1:0] data_lines_o,
   input wire logic data_lines_oe,
   input wire logic [DATA_W-1:0] data_lines_i
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sel_pair_a: assert property (select_low_n == !select_high)
      else $error("selects disagree");
   drive_guard_a: assert property (data_lines_oe |-> !select_low_n && out_enable_n)
      else $error("host drives outside a write");
   addr_hold_a: assert property (!write_strobe_n && $past(!write_strobe_n) |-> $stable(word_address))
      else $error("address moved under strobe");
   strobe_width_a: assert property ($fell(write_strobe_n) |->
      (!write_strobe_n)[*8] ##1 (!write_strobe_n)[*5] ##1 write_strobe_n) else $error("strobe width wrong");
   data_overlap_a: assert property ($rose(write_strobe_n) |-> data_lines_oe && $past(data_lines_oe, 7))
      else $error("write data too short");
   late_select_a: assert property ($fell(write_strobe_n) |-> $fell(select_low_n))
      else $error("select not with strobe");
   read_hold_a: assert property ($fell(out_enable_n) |-> $fell(select_low_n) ##1
      (!select_low_n && !out_enable_n && $stable(word_address))[*8] ##1 (!select_low_n)[*4])
      else $error("read too short");
   retain_desel_a: assert property (retain_req[*6] ##0 $past(req_ready, 5) |-> select_low_n && !select_high)
      else $error("selected in retention");
   recover_wait_a: assert property ($fell(retain_req) |-> (!req_ready)[*8] ##1 (!req_ready)[*6])
      else $error("recovery too short");
endmodule // srm_host_mon
bind srm_host srm_host_mon u_mon (.*);

/* File: bench/srm_host_tb_top.sv */
// self-checking bench for the sram host controller
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module srm_host_tb_top import srm_pkg::*;;
   logic core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, retain_req = 1'b0;
   logic [ADDR_W-1:0] req_addr = '0, word_address;
   logic [DATA_W-1:0] req_wdata = '0, rd_data, data_lines_o, data_lines_i;
   logic req_ready, rd_valid, select_low_n, select_high, out_enable_n, write_strobe_n, data_lines_oe;
   int fail_count = 0, check_count = 0, n;
   // rows: write flag, address, write data or expected read data
   logic [ADDR_W+DATA_W:0] rows [6] = '{{1'b1, 13'h1FFF, 8'hA5}, {1'b1, 13'h0000, 8'h5A},
      {1'b0, 13'h1FFF, 8'hA5}, {1'b0, 13'h0000, 8'h5A}, {1'b1, 13'h1FFF, 8'h3C}, {1'b0, 13'h1FFF, 8'h3C}};
   always #2 core_clk = ~core_clk;
   srm_host dut (.*);
   srm_mem_model u_mem (.*);
   task automatic wait_ready();
      n = 0;
      do begin @(posedge core_clk); n++; end while (req_ready !== 1'b1 && n < 100);
      if (n >= 100) fail_count++;
   endtask
   task automatic xfer(input logic [ADDR_W+DATA_W:0] r);
      wait_ready();
      req_valid <= 1'b1;
      {req_write, req_addr, req_wdata} <= r;
      @(posedge core_clk);
      req_valid <= 1'b0;
      n = 0;
      if (!r[ADDR_W+DATA_W]) begin
         do begin @(posedge core_clk); n++; end while (rd_valid !== 1'b1 && n < 40);
         `CHK(n, 15)
         `CHK(rd_data, r[DATA_W-1:0])
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      foreach (rows[i]) xfer(rows[i]);
      wait_ready();
      retain_req <= 1'b1;
      repeat (20) @(posedge core_clk);
      `CHK({select_low_n, select_high, req_ready}, 3'b100)
      retain_req <= 1'b0;
      wait_ready();
      `CHK(n >= 14, 1'b1)
      xfer({1'b0, 13'h0000, 8'h5A});
      // reset lands in the middle of a write
      wait_ready();
      req_valid <= 1'b1;
      {req_write, req_addr, req_wdata} <= {1'b1, 13'h0ABC, 8'hFF};
      repeat (4) @(posedge core_clk);
      rst <= 1'b1;
      req_valid <= 1'b0;
      @(posedge core_clk);
      `CHK({select_low_n, select_high, write_strobe_n, data_lines_oe, req_ready}, 5'b10100)
      rst <= 1'b0;
      xfer({1'b0, 13'h1FFF, 8'h3C});
      give_verdict();
   end
   initial begin
      #20000;
      fail_count++;
      give_verdict();
   end
endmodule // srm_host_tb_top

/* File: bench/srm_mem_model.sv */
// behavioural 8k x 8 asynchronous memory
`timescale 1ns/1ns
module srm_mem_model import srm_pkg::*; (
   // clock for the idle bus pattern
   input wire logic core_clk,
   // memory pins
   input wire logic select_low_n,
   input wire logic select_high,
   input wire logic out_enable_n,
   input wire logic write_strobe_n,
   input wire logic [ADDR_W-1:0] word_address,
   input wire logic [DATA_W-1:0] data_lines_o,
   input wire logic data_lines_oe,
   output logic [DATA_W-1:0] data_lines_i
);
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic ok = 1'b0;
   wire sel = !select_low_n && select_high;
   wire rd = sel && !out_enable_n && write_strobe_n;
   wire wr = sel && !write_strobe_n;
   // data shows only a full access after address or enable
   always @(rd, word_address) begin
      ok = 1'b0;
      ok <= #T_ADDR_ACCESS_NS rd;
   end
   always @(negedge wr) mem[word_address] = data_lines_i;
   // floats at once; a floating bus toggles so stale data cannot pass
   assign data_lines_i = data_lines_oe ? data_lines_o :
      (rd && ok) ? mem[word_address] : {DATA_W{core_clk}} ^ 8'hA6;
endmodule // srm_mem_model

/* File: hw/srm_host.sv */
// host side controller driving an asynchronous 8k x 8 sram
`timescale 1ns/1ns
// Operation
// - select needs low-n low and high high
// - address valid before select on reads; here address and select change on the same edge
// - write while both selects and strobe active
// - address changes only with strobe high
// - address and select 50 ns before end
// - data 25 ns before end, hold 0
// - strobe exceeds float plus overlap
// - deselect before and during retention
// - wait read cycle after recovery
module srm_host import srm_pkg::*; (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // user request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic rd_valid,
   output logic [DATA_W-1:0] rd_data,
   // low supply retention request, level
   input wire logic retain_req,
   // memory pins
   output logic select_low_n,
   output logic select_high,
   output logic out_enable_n,
   output logic write_strobe_n,
   output logic [ADDR_W-1:0] word_address,
   output logic [DATA_W-1:0] data_lines_o,
   output logic data_lines_oe,
   input wire logic [DATA_W-1:0] data_lines_i
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam srm_pins_t PINS_IDLE = '{select_low_n: 1'b1, select_high: 1'b0, out_enable_n: 1'b1,
      write_strobe_n: 1'b1, word_address: '0, data_out: '0, data_oe: 1'b0};
   srm_regs_t r_q;
   srm_regs_t r_d;
   logic retain_level;

   // retention request is asynchronous: three stages, level high only while last two are both high
   always_comb begin
      retain_level = r_q.retain_sync[2] & r_q.retain_sync[1];
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      r_d = r_q;
      r_d.retain_sync = {r_q.retain_sync[1:0], retain_req};
      r_d.rd_valid = 1'b0;
      if (r_q.cnt != CNT_ZERO) begin
         r_d.cnt = r_q.cnt - CNT_ONE;
      end
      if (r_q.wcnt != CNT_ZERO) begin
         r_d.wcnt = r_q.wcnt - CNT_ONE;
      end
      unique case (r_q.state)
         SRM_IDLE: begin
            r_d.pins = r_q.pins;
            r_d.pins.select_low_n = 1'b1;
            r_d.pins.select_high = 1'b0;
            r_d.pins.out_enable_n = 1'b1;
            r_d.pins.write_strobe_n = 1'b1;
            r_d.pins.data_oe = 1'b0;
            r_d.ready = 1'b1;
            if (r_q.cnt != CNT_ZERO) begin
               r_d.ready = 1'b0; // oe float gap after a read
            end else if (retain_level) begin
               r_d.state = SRM_RETAIN;
               r_d.ready = 1'b0;
            end else if (req_valid && r_q.ready) begin
               r_d.ready = 1'b0;
               // address placed with select; a write drops strobe on the same edge
               r_d.pins.word_address = req_addr;
               r_d.pins.select_low_n = 1'b0;
               r_d.pins.select_high = 1'b1;
               if (req_write) begin
                  r_d.state = SRM_WRITE;
                  r_d.pins.write_strobe_n = 1'b0;
                  r_d.pins.data_out = req_wdata;
                  r_d.cnt = WR_PULSE_CYC;
                  r_d.wcnt = WR_FLOAT_CYC;
               end else begin
                  r_d.state = SRM_READ;
                  r_d.pins.out_enable_n = 1'b0;
                  r_d.cnt = RD_ACCESS_CYC;
               end
            end
         end
         SRM_READ: begin
            if (r_q.cnt == CNT_ONE) begin
               // sample before address or controls move
               r_d.rd_data = data_lines_i;
               r_d.rd_valid = 1'b1;
               r_d.pins.select_low_n = 1'b1;
               r_d.pins.select_high = 1'b0;
               r_d.pins.out_enable_n = 1'b1;
               r_d.cnt = RD_FLOAT_CYC;
               r_d.state = SRM_IDLE;
            end
         end
         SRM_WRITE: begin
            // host drives data only once memory has floated
            if (r_q.wcnt == CNT_ONE) begin
               r_d.pins.data_oe = 1'b1;
            end
            if (r_q.cnt == CNT_ONE) begin
               // strobe rises first; address, select and data held
               r_d.pins.write_strobe_n = 1'b1;
               r_d.cnt = WR_CYCLE_CYC > WR_PULSE_CYC ? WR_CYCLE_CYC - WR_PULSE_CYC : CNT_ONE;
               r_d.state = SRM_WR_END;
            end
         end
         SRM_WR_END: begin
            r_d.pins.data_oe = 1'b0;
            r_d.pins.select_low_n = 1'b1;
            r_d.pins.select_high = 1'b0;
            if (r_q.cnt <= CNT_ONE) begin
               r_d.cnt = CNT_ZERO;
               r_d.state = SRM_IDLE;
            end
         end
         SRM_RETAIN: begin
            r_d.pins.select_low_n = 1'b1;
            r_d.pins.select_high = 1'b0;
            r_d.ready = 1'b0;
            if (!retain_level) begin
               r_d.cnt = RECOVERY_CYC;
               r_d.state = SRM_RECOVER;
            end
         end
         SRM_RECOVER: begin
            if (r_q.cnt <= CNT_ONE) begin
               r_d.cnt = CNT_ZERO;
               r_d.state = SRM_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         r_q <= '{state: SRM_IDLE, cnt: '0, wcnt: '0, pins: PINS_IDLE, ready: 1'b0,
            rd_valid: 1'b0, rd_data: '0, retain_sync: '0};
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign req_ready = r_q.ready;
   assign rd_valid = r_q.rd_valid;
   assign rd_data = r_q.rd_data;
   assign select_low_n = r_q.pins.select_low_n;
   assign select_high = r_q.pins.select_high;
   assign out_enable_n = r_q.pins.out_enable_n;
   assign write_strobe_n = r_q.pins.write_strobe_n;
   assign word_address = r_q.pins.word_address;
   assign data_lines_o = r_q.pins.data_out;
   assign data_lines_oe = r_q.pins.data_oe;
endmodule // srm_host

/* File: hw/srm_pkg.sv */
// package for the asynchronous sram host controller
package srm_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 4;
   // ----------------------------------------
   // timing figures in ns
   // ----------------------------------------
   localparam int T_READ_CYCLE_NS = 55;
   localparam int T_ADDR_ACCESS_NS = 55;
   localparam int T_OE_ACCESS_NS = 30;
   localparam int T_OE_FLOAT_NS = 20;
   localparam int T_WRITE_CYCLE_NS = 55;
   localparam int T_WRITE_PULSE_NS = 45;
   localparam int T_ADDR_TO_END_NS = 50;
   localparam int T_DATA_OVERLAP_NS = 25;
   localparam int T_WRITE_FLOAT_NS = 20;
   localparam int T_RECOVERY_NS = 55;
   // ----------------------------------------
   // cycle counts, least times rounded up
   // ----------------------------------------
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] RD_ACCESS_CYC =
      CNT_W'((T_ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RD_FLOAT_CYC =
      CNT_W'((T_OE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // write pulse must exceed float delay plus data overlap and the pulse width
   localparam int WR_PULSE_NS = (T_WRITE_FLOAT_NS + T_DATA_OVERLAP_NS + CLK_PERIOD_NS > T_WRITE_PULSE_NS) ?
      T_WRITE_FLOAT_NS + T_DATA_OVERLAP_NS + CLK_PERIOD_NS : T_WRITE_PULSE_NS;
   localparam logic [CNT_W-1:0] WR_PULSE_CYC =
      CNT_W'((WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WR_FLOAT_CYC =
      CNT_W'((T_WRITE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WR_CYCLE_CYC =
      CNT_W'((T_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RECOVERY_CYC =
      CNT_W'((T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      SRM_IDLE,
      SRM_READ,
      SRM_WRITE,
      SRM_WR_END,
      SRM_RETAIN,
      SRM_RECOVER
   } srm_state_t;

   typedef struct packed {
      logic select_low_n;
      logic select_high;
      logic out_enable_n;
      logic write_strobe_n;
      logic [ADDR_W-1:0] word_address;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
   } srm_pins_t;

   typedef struct packed {
      srm_state_t state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] wcnt;
      srm_pins_t pins;
      logic ready;
      logic rd_valid;
      logic [DATA_W-1:0] rd_data;
      logic [2:0] retain_sync;
   } srm_regs_t;
endpackage
